// ### etc_map.vh
// register map, field positions, reset values and timing figures of the
// edge transition counter; definitions only, included by bare name
`ifndef ETC_MAP_VH
`define ETC_MAP_VH

// byte offsets on the wishbone bus, one aligned word each
`define ETC_ADR_CTRL      8'h00
`define ETC_ADR_THRESH    8'h04
`define ETC_ADR_TIMEOUT   8'h08
`define ETC_ADR_COUNT     8'h0C
`define ETC_ADR_STATUS    8'h10
`define ETC_ADR_MASK      8'h14

// control fields
`define ETC_CTRL_MODE_LO  0
`define ETC_CTRL_MODE_HI  1
`define ETC_CTRL_IN_SEL   2
`define ETC_CTRL_GATE_SEL 3
`define ETC_CTRL_CLR_SEL  4
`define ETC_CTRL_WIDTH    5

// edge modes
`define ETC_MODE_RISE     2'h0
`define ETC_MODE_FALL     2'h1
`define ETC_MODE_BOTH     2'h2

// status and mask bits
`define ETC_ST_FLAG       0
`define ETC_ST_TIMEOUT    1
`define ETC_ST_SAT        2
`define ETC_ST_WIDTH      3

// reset values
`define ETC_RST_CTRL      5'h00
`define ETC_RST_THRESH    32'h00000001
`define ETC_RST_TIMEOUT   16'h0000
`define ETC_RST_MASK      3'h0

// timing: update clock rate and one millisecond of timeout (25000 clocks)
`define ETC_CLK_HZ        25000000
`define ETC_MS_PER_S      1000
`define ETC_CYC_PER_MS    16'h61A8

`endif

// ### etc_top.v
// edge transition counter with a classic wishbone register slave
// assumes pins from other channels are asynchronous and one clock mclk_i
// clear and gate act on levels; only the counted input is edge-qualified
`timescale 1ns/1ns
`default_nettype none
`include "etc_map.vh"

module etc_top #(
    parameter [15:0] CYC_PER_MS = `ETC_CYC_PER_MS
) (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        sig_in_i,
    input  wire        gate_in_i,
    input  wire        count_clear_source_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [31:0] count_o,
    output reg         flag_o,
    output reg         irq_o
);

    // byte lane merge for wishbone writes
    // lanes with a low enable keep the old bits of the register
    function [31:0] etc_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      k;
        begin
            etc_merge = old_v;
            for (k = 0; k < 4; k = k + 1)
                if (sel[k])
                    etc_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
    endfunction

    // edge qualification by mode
    function etc_edge;
        input [1:0] mode;
        input       prev;
        input       cur;
        begin
            case (mode)
                `ETC_MODE_RISE: etc_edge = ~prev & cur;
                `ETC_MODE_FALL: etc_edge = prev & ~cur;
                `ETC_MODE_BOTH: etc_edge = prev ^ cur;
                default:        etc_edge = 1'b0;
            endcase
        end
    endfunction

    // write strobe for one register offset
    function etc_hit;
        input       wr;
        input [7:0] adr;
        input [7:0] off;
        begin
            etc_hit = wr & (adr == off);
        end
    endfunction

    reg [`ETC_CTRL_WIDTH-1:0] ctrl;
    reg [31:0]                thresh;
    reg [15:0]                timeout_ms;
    reg [`ETC_ST_WIDTH-1:0]   status;
    reg [`ETC_ST_WIDTH-1:0]   mask;
    reg [31:0]                count;

    reg [2:0]                 sync_a;
    reg [2:0]                 sync_b;
    reg                       in_prev;
    reg                       flag_prev;

    reg [15:0]                pre_cnt;
    reg [15:0]                ms_cnt;

    wire                      bus_req;
    wire                      bus_wr;
    wire                      in_lvl;
    wire                      gate_lvl;
    wire                      clr_lvl;
    wire                      edge_ok;
    wire                      at_max;
    wire                      tmo_fire;
    wire                      ms_tick;
    reg  [31:0]               next_rdata;
    reg  [31:0]               next_count;
    wire [`ETC_ST_WIDTH-1:0]  st_set;
    wire [`ETC_ST_WIDTH-1:0]  st_clr;

    // register write decode and sticky events
    wire                      ev_flag;
    wire                      ev_tmo;
    wire                      ev_sat;
    wire [31:0]               wr_word;
    wire                      wr_ctrl;
    wire                      wr_thresh;
    wire                      wr_tmo;
    wire                      wr_mask;
    wire                      wr_status;
    reg  [31:0]               next_thresh;

    assign bus_req = wb_cyc_i & wb_stb_i;
    // write lands on the edge where the master sees ack high
    assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

    // two-stage synchronisers; only the second stage is read
    // a level shorter than one clock may fall between samples and go uncounted
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync_a  <= 3'h0;
            sync_b  <= 3'h0;
            in_prev <= 1'b0;
        end
        else
        begin
            sync_a  <= {count_clear_source_i, gate_in_i, sig_in_i};
            sync_b  <= sync_a;
            in_prev <= in_lvl;
        end
    end

    // source selection: a clear select bit picks the constant default
    // a source switched in while high shows one rising edge, as a real input would
    assign in_lvl   = ctrl[`ETC_CTRL_IN_SEL]   ? sync_b[0] : 1'b0;
    assign gate_lvl = ctrl[`ETC_CTRL_GATE_SEL] ? sync_b[1] : 1'b1;
    assign clr_lvl  = ctrl[`ETC_CTRL_CLR_SEL]  ? sync_b[2] : 1'b0;

    // countable edge: selected edge while gate is open
    assign edge_ok = gate_lvl &
                     etc_edge(ctrl[`ETC_CTRL_MODE_HI:`ETC_CTRL_MODE_LO], in_prev, in_lvl);
    assign at_max  = (count == 32'hFFFFFFFF);

    // idle timer: prescaler gives ms ticks, restarted by each countable edge
    // the timer runs on while the gate is closed; only a countable edge, its own expiry or a zero timeout restarts it
    assign ms_tick  = (pre_cnt == (CYC_PER_MS - 16'h0001));
    assign tmo_fire = (timeout_ms != 16'h0000) & ~edge_ok &
                      ms_tick & (ms_cnt == (timeout_ms - 16'h0001));

    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pre_cnt <= 16'h0000;
            ms_cnt  <= 16'h0000;
        end
        else if (edge_ok || tmo_fire || timeout_ms == 16'h0000)
        begin
            pre_cnt <= 16'h0000;
            ms_cnt  <= 16'h0000;
        end
        else if (ms_tick)
        begin
            pre_cnt <= 16'h0000;
            ms_cnt  <= ms_cnt + 16'h0001;
        end
        else
        begin
            pre_cnt <= pre_cnt + 16'h0001;
        end
    end

    // count update; clearing beats counting, top value holds
    // holding the top value instead of wrapping keeps a runaway count visible
    always @*
    begin
        next_count = count;
        if (clr_lvl || tmo_fire)
            next_count = 32'h00000000;
        else if (edge_ok && !at_max)
            next_count = count + 32'h00000001;
    end

    // count, its output copy and the flag all settle on the same edge
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count     <= 32'h00000000;
            count_o   <= 32'h00000000;
            flag_o    <= 1'b0;
            flag_prev <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            count_o   <= next_count;
            flag_o    <= (next_count >= next_thresh);
            flag_prev <= flag_o;
        end
    end

    // sticky events: flag rising, timeout clearing a live count, edge lost at the top
    assign ev_flag = flag_o & ~flag_prev;
    assign ev_tmo  = tmo_fire & (count != 32'h00000000);
    assign ev_sat  = edge_ok & at_max & ~clr_lvl;
    assign st_set  = {ev_sat, ev_tmo, ev_flag};
    // write one to clear; all status bits sit in the low byte lane
    assign st_clr  = (wr_status && wb_sel_i[0]) ? wb_dat_i[`ETC_ST_WIDTH-1:0] :
                     {`ETC_ST_WIDTH{1'b0}};

    // bus write strobes; write data merged into the old word by byte lane
    assign wr_word   = etc_merge(next_rdata, wb_dat_i, wb_sel_i);
    assign wr_ctrl   = etc_hit(bus_wr, wb_adr_i, `ETC_ADR_CTRL);
    assign wr_thresh = etc_hit(bus_wr, wb_adr_i, `ETC_ADR_THRESH);
    assign wr_tmo    = etc_hit(bus_wr, wb_adr_i, `ETC_ADR_TIMEOUT);
    assign wr_mask   = etc_hit(bus_wr, wb_adr_i, `ETC_ADR_MASK);
    assign wr_status = etc_hit(bus_wr, wb_adr_i, `ETC_ADR_STATUS);

    // threshold as it stands after this edge, so the flag never lags a write
    always @*
    begin
        next_thresh = thresh;
        if (wr_thresh)
            next_thresh = wr_word;
    end

    // control: a select bit of zero keeps the constant default source
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl <= `ETC_RST_CTRL;
        end
        else if (wr_ctrl)
        begin
            ctrl <= wr_word[`ETC_CTRL_WIDTH-1:0];
        end
    end

    // flag threshold; default one so the first counted edge raises the flag
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            thresh <= `ETC_RST_THRESH;
        end
        else
        begin
            thresh <= next_thresh;
        end
    end

    // idle timeout in ms; zero parks the timer
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            timeout_ms <= `ETC_RST_TIMEOUT;
        end
        else if (wr_tmo)
        begin
            timeout_ms <= wr_word[15:0];
        end
    end

    // interrupt mask, same layout as status
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mask <= `ETC_RST_MASK;
        end
        else if (wr_mask)
        begin
            mask <= wr_word[`ETC_ST_WIDTH-1:0];
        end
    end

    // sticky status; a set in the same cycle as its clear wins
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            status <= {`ETC_ST_WIDTH{1'b0}};
        end
        else
        begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    // interrupt level, one clock behind the status bits it reflects
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(status & mask);
        end
    end

    // read mux; unmapped offsets read zero
    // reading the count never disturbs it; there is no read-to-clear
    always @*
    begin
        case (wb_adr_i)
            `ETC_ADR_CTRL:    next_rdata = {27'h0, ctrl};
            `ETC_ADR_THRESH:  next_rdata = thresh;
            `ETC_ADR_TIMEOUT: next_rdata = {16'h0, timeout_ms};
            `ETC_ADR_COUNT:   next_rdata = count;
            `ETC_ADR_STATUS:  next_rdata = {29'h0, status};
            `ETC_ADR_MASK:    next_rdata = {29'h0, mask};
            default:          next_rdata = 32'h00000000;
        endcase
    end

    // single-wait-state ack, dropped the cycle after it was given
    // read data is loaded when the request is taken and stands until the next access
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o)
                wb_dat_o <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// ### etc_dummy_never.v
// holds no logic; the whole counter sits in etc_top
// assumes nothing of its surroundings
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ### etc_sva.sv
// port checker for the edge transition counter
// assumes writes to control, threshold and mask carry all four byte enables
`timescale 1ns/1ns
`default_nettype none
module etc_sva #(
    parameter [15:0] CYC_PER_MS = 16'h0004
) (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic        sig_in_i,
    input wire logic        gate_in_i,
    input wire logic        count_clear_source_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [31:0] count_o,
    input wire logic        flag_o,
    input wire logic        irq_o
);
    logic [31:0] thr;
    logic [4:0]  ctl;
    logic [2:0]  msk;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // shadow of control, threshold and mask, updated at the ack edge like the block
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            thr <= 32'h1;
            ctl <= 5'h0;
            msk <= 3'h0;
        end
        else if (wb_ack_o && wb_we_i)
        begin
            if (wb_adr_i == 8'h04) thr <= wb_dat_i;
            if (wb_adr_i == 8'h00) ctl <= wb_dat_i[4:0];
            if (wb_adr_i == 8'h14) msk <= wb_dat_i[2:0];
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("access not answered");
    flag_level_a: assert property (flag_o == (count_o >= thr)) else $error("flag wrong");
    count_step_a: assert property (count_o != $past(count_o) |->
        count_o == $past(count_o) + 32'h1 || count_o == 32'h0) else $error("count jumped");
    clear_hold_a: assert property ((ctl[4] && count_clear_source_i)[*3] |=> count_o == 0)
        else $error("count not held clear");
    gate_block_a: assert property ((ctl[3] && !gate_in_i)[*3] |=>
        $stable(count_o) || count_o == 0) else $error("counted while gated");
    const_in_a: assert property ((!ctl[2])[*4] |=> $stable(count_o) || count_o == 0)
        else $error("counted constant input");
    irq_mask_a: assert property (msk == 0 ##1 msk == 0 |-> !irq_o) else $error("masked irq");
    count_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C |->
        wb_dat_o == $past(count_o)) else $error("count read differs");
    unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |->
        wb_dat_o == 0) else $error("unmapped read not zero");
    cover property (flag_o && irq_o);
    cover property (count_o != 0 ##1 count_o == 0);
    cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h10);
endmodule
bind etc_top etc_sva #(.CYC_PER_MS(CYC_PER_MS)) chk (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .sig_in_i(sig_in_i),
    .gate_in_i(gate_in_i),
    .count_clear_source_i(count_clear_source_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .count_o(count_o),
    .flag_o(flag_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ### etc_src.sv
// pulse source standing for another channel's digital output
// assumes go_i is a one-cycle request; busy_o high while pulses run
`timescale 1ns/1ns
`default_nettype none
module etc_src (
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [3:0] n_i,
    output logic            sig_o,
    output wire logic       busy_o
);
    logic [4:0] left;
    logic [1:0] tick;
    initial sig_o = 1'h0;
    initial left = 5'h0;
    assign busy_o = left != 5'h0;
    // each level lasts two or four clocks so no edge slips past sampling
    always @(posedge mclk_i)
    begin
        if (go_i)
        begin
            left <= {n_i, 1'h0};
            tick <= 2'h0;
        end
        else if (busy_o)
        begin
            if (tick == (slow_i ? 2'h3 : 2'h1))
            begin
                tick <= 2'h0;
                sig_o <= ~sig_o;
                left <= left - 5'h1;
            end
            else tick <= tick + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ### etc_top_test.sv
// self-checking bench for etc_top with a pulse source on the counted input
// assumes the one-wait wishbone answer and a 4-clock millisecond
`timescale 1ns/1ns
`default_nettype none
module etc_top_test;
    logic        mclk_i = 1'h0, rst_b_i = 1'h0, gate = 1'h1, clr = 1'h0;
    logic        go = 1'h0, slow = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0]  n = 4'h0;
    logic [3:0]  sel = 4'h0, wsel = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    wire  [31:0] rdat, count;
    wire         sig, busy, ack, flag, irq;
    logic [31:0] q[$];
    string       nq[$];
    integer      err_count = 0, num_checks = 0, seed = 32'h6EDAA86D, i, k;
    etc_top #(.CYC_PER_MS(16'h0004)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .sig_in_i(sig), .gate_in_i(gate), .count_clear_source_i(clr), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .count_o(count), .flag_o(flag), .irq_o(irq));
    etc_src src (.mclk_i(mclk_i), .go_i(go), .slow_i(slow), .n_i(n), .sig_o(sig),
        .busy_o(busy));
    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle; released only after the edge that samples ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer t;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        t = 0;
        @(posedge mclk_i);
        while (ack !== 1'h1 && t < 50)
        begin
            @(posedge mclk_i);
            t++;
        end
        // a wait that runs out counts as a mismatch; the run goes on to the verdict
        if (t == 50)
            chk(32'(ack), 32'h1, "ack");
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge mclk_i);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string what);
        q.push_back(e);
        nq.push_back(what);
        wb(1'h0, a, 32'h0);
    endtask
    task pulses(input logic [3:0] c);
        integer t;
        n <= c; slow <= 1'($random(seed)); go <= 1'h1;
        @(posedge mclk_i);
        go <= 1'h0;
        @(posedge mclk_i);
        t = 0;
        while (busy === 1'h1 && t < 200) begin @(posedge mclk_i); t++; end
        if (t == 200)
            chk(32'(busy), 32'h0, "busy");
        repeat (6) @(posedge mclk_i); // sync, edge and count stages
    endtask
    // read data is judged against the oldest note when its ack shows
    always @(posedge mclk_i)
        if (ack === 1'h1 && we === 1'h0 && q.size() > 0)
            chk(rdat, q.pop_front(), nq.pop_front());
    initial
    begin
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        @(posedge mclk_i);
        rd(8'h00, 32'h0, "ctrl");
        rd(8'h04, 32'h1, "thresh");
        rd(8'h08, 32'h0, "timeout");
        rd(8'h18, 32'h0, "unmapped");
        pulses(4'h3);
        rd(8'h0C, 32'h0, "count");
        $display("reset values done");
        wb(1'h1, 8'h14, 32'h1);
        for (k = 0; k < 4; k++)
        begin
            wb(1'h1, 8'h00, 32'h1C | k);
            clr <= 1'h1;
            repeat (5) @(posedge mclk_i);
            clr <= 1'h0;
            rd(8'h0C, 32'h0, "count");
            i = 1 + ($random(seed) & 7);
            pulses(i[3:0]);
            rd(8'h0C, 32'(k == 2 ? 2 * i : (k == 3 ? 0 : i)), "count");
            chk(32'(flag), 32'(k != 3), "flag");
            rd(8'h10, 32'(k != 3), "status");
            chk(32'(irq), 32'(k != 3), "irq");
            wb(1'h1, 8'h10, 32'h7);
            rd(8'h10, 32'h0, "status");
        end
        $display("edge modes done");
        wb(1'h1, 8'h00, 32'h1C);
        gate <= 1'h0;
        pulses(4'h5);
        rd(8'h0C, 32'h0, "count");
        gate <= 1'h1;
        pulses(4'h2);
        wb(1'h1, 8'h04, 32'h3);
        chk(32'(flag), 32'h0, "flag");
        pulses(4'h1);
        chk(32'(flag), 32'h1, "flag");
        $display("gate and threshold done");
        wb(1'h1, 8'h08, 32'h1);
        repeat (20) @(posedge mclk_i);
        rd(8'h0C, 32'h0, "count");
        rd(8'h10, 32'h3, "status");
        // a clear without the low byte lane must leave the sticky bits alone
        wsel = 4'hE;
        wb(1'h1, 8'h10, 32'h7);
        wsel = 4'hF;
        rd(8'h10, 32'h3, "status");
        $display("timeout done");
        print_verdict;
    end
endmodule
`default_nettype wire
